//--- scsp_defs.svh
// constants for the switch control serial/parallel block
`ifndef SCSP_DEFS_SVH
`define SCSP_DEFS_SVH
`define SCSP_FRAME_BITS 16
`define SCSP_FRAME_MSB 15
`define SCSP_BIT_WR_EN 7
`define SCSP_BIT_FAULT_STATUS_BIT 6
`define SCSP_BIT_SLEEP 5
`define SCSP_BIT_FLT_DIS 4
`define SCSP_BIT_HVCMP_DIS 3
`define SCSP_BIT_PUMP_EN 1
`define SCSP_REG_RESET 8'h00
`define SCSP_HV_ALL_OFF 4'h0
`define SCSP_CLK_PERIOD_NS 50
`define SCSP_POR_VALID_NS 2500000
`define SCSP_POR_CYCLES (`SCSP_POR_VALID_NS / `SCSP_CLK_PERIOD_NS)
`define SCSP_POR_CNT_W 17
`endif

//--- scsp_pkg.sv
// types shared by the switch control serial/parallel block
package scsp_pkg;
  typedef struct packed {
    logic sck;
    logic sdi;
    logic chip_select_n;
  } scsp_serial_t;

  typedef struct packed {
    logic [7:0] config_fault_register;
    logic [7:0] switch_output_register;
  } scsp_regs_t;

  typedef enum logic [1:0] {
    SCSP_ST_POR,
    SCSP_ST_RUN,
    SCSP_ST_SHUT
  } scsp_state_t;
endpackage

//--- scsp_sync2.sv
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module scsp_sync2 (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta;
  logic next_meta;
  logic next_sync;

  always_comb begin
    next_meta = async_in;
    next_sync = meta;
    if (!rst_n_in) begin
      next_meta = 1'b0;
      next_sync = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    meta <= next_meta;
    sync_out <= next_sync;
  end
endmodule

//--- scsp_top.sv
// serial/parallel control logic of a high-voltage switch driver
// Behaviour
// R1: mode low selects 16-bit serial interface, mode high selects parallel control.
// R2: host keeps serial clock at or below 33 MHz.
// R3: chip select idles high in serial mode, fourth control idles low in parallel.
// R4: falling chip select drives outgoing word MSB onto serial output at once.
// R5: serial input sampled on rising clock; clock idle while chip select high.
// R6: next outgoing bit driven onto serial output at each falling clock.
// R7: 16-bit shift register; previous word shifts out while new word shifts in.
// R8: rising chip select loads registers only when write-enable bit is one.
// R9: frame is write enable, seven control/status bits, then switch byte.
// R10: switch bits 3..0 drive outputs D..A; upper bits written as zero.
// R11: control bits: write enable, status, sleep, shutdown disable, comparator off, pump.
// R12: serial mode ignores pump and shutdown pins, uses register bits.
// R13: reset clears both registers to zero.
// R14: daisy chain shifts 16 bits per device within one chip-select low.
// R15: parallel mode with polarity low: controls 1..4 drive outputs A..D.
// R16: host uses only the valid parallel codes.
// R17: two under-voltage faults ORed; fault output pulled low while either present.
// R18: hv comparator off by register bit in serial, by pump pin low in parallel.
// R19: fault output stays released until both supplies passed enable thresholds.
// R20: fault latches status bit until written zero; pin releases when fault clears.
// R21: shutdown enabled: fault forces outputs low, stops pump until pump toggled.
// R22: unfaulted supply still monitored; fault persists until both supplies good.
// R23: host holds pump enable low at least 500 ns to restart.
// R24: inputs treated invalid for 2.5 ms after supplies applied.
// R25: more than 16 clocks: last 16 bits shifted in are acted on.
`timescale 1ns/1ps
// macros must exist before the parameter default below reads them
`include "scsp_defs.svh"
module scsp_top
  import scsp_pkg::*;
#(
  parameter int POR_CYCLES = `SCSP_POR_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic mode_select_in,
  input wire logic polarity_in,
  input wire logic sck_ctrl1_in,
  input wire logic sdi_ctrl2_in,
  input wire logic sdo_ctrl3_in,
  input wire logic chip_select_n_in,
  input wire logic pump_enable_pin_in,
  input wire logic fault_shutdown_pin_in,
  input wire logic logic_uv_fault_in,
  input wire logic hv_uv_fault_in,
  input wire logic logic_supply_ready_in,
  input wire logic hv_supply_ready_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  output logic fault_out_n_out,
  output logic fault_out_n_oe_out,
  output logic hv_output_a_out,
  output logic hv_output_b_out,
  output logic hv_output_c_out,
  output logic hv_output_d_out,
  output logic pump_run_out,
  output logic sleep_out,
  output logic hv_comparator_enable_out
);
  // every pin input except clock and reset passes two flops before use
  localparam int NSYNC = 12;
  logic [NSYNC-1:0] raw_pins;
  logic [NSYNC-1:0] pins;

  assign raw_pins = {mode_select_in, polarity_in, sck_ctrl1_in, sdi_ctrl2_in,
                     sdo_ctrl3_in, chip_select_n_in, pump_enable_pin_in,
                     fault_shutdown_pin_in, logic_uv_fault_in, hv_uv_fault_in,
                     logic_supply_ready_in, hv_supply_ready_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      scsp_sync2 u_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .async_in(raw_pins[gi]),
        .sync_out(pins[gi])
      );
    end
  endgenerate

  logic mode_par;
  logic polarity;
  logic parallel_ctrl_1;
  logic parallel_ctrl_2;
  logic parallel_ctrl_3;
  logic parallel_ctrl_4;
  logic pump_enable_pin;
  logic fault_shutdown_pin;
  logic logic_uv;
  logic hv_uv;
  logic logic_ready;
  logic hv_ready;
  scsp_serial_t ser;

  assign mode_par = pins[11];
  assign polarity = pins[10];
  assign parallel_ctrl_1 = pins[9];
  assign parallel_ctrl_2 = pins[8];
  assign parallel_ctrl_3 = pins[7];
  assign parallel_ctrl_4 = pins[6];
  assign pump_enable_pin = pins[5];
  assign fault_shutdown_pin = pins[4];
  assign logic_uv = pins[3];
  assign hv_uv = pins[2];
  assign logic_ready = pins[1];
  assign hv_ready = pins[0];
  assign ser.sck = pins[9];
  assign ser.sdi = pins[8];
  assign ser.chip_select_n = pins[6];

  // ---------------- serial engine state ----------------
  scsp_regs_t regs;
  scsp_regs_t next_regs;
  logic [`SCSP_FRAME_MSB:0] shreg;
  logic [`SCSP_FRAME_MSB:0] next_shreg;
  logic sck_q;
  logic next_sck_q;
  logic cs_n_q;
  logic next_cs_n_q;
  logic next_sdo;
  logic next_sdo_oe;

  // ---------------- fault / power state ----------------
  scsp_state_t state;
  scsp_state_t next_state;
  logic [`SCSP_POR_CNT_W-1:0] por_cnt;
  logic [`SCSP_POR_CNT_W-1:0] next_por_cnt;
  logic armed;
  logic next_armed;
  logic pump_low_seen;
  logic next_pump_low_seen;
  logic next_fault_n;
  logic next_fault_oe;
  logic [3:0] next_hv;
  logic next_pump_run;
  logic next_sleep;
  logic next_cmp_en;

  // effective controls, picked per mode
  logic serial_mode;
  logic eff_pump;
  logic eff_shutdown_dis;
  logic hv_cmp_on;
  logic fault_now;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  always_comb begin
    serial_mode = !mode_par; // R1
    eff_pump = serial_mode ? regs.config_fault_register[`SCSP_BIT_PUMP_EN]
                           : pump_enable_pin; // R12
    eff_shutdown_dis = serial_mode ? regs.config_fault_register[`SCSP_BIT_FLT_DIS]
                                   : fault_shutdown_pin; // R12
    hv_cmp_on = serial_mode ? !regs.config_fault_register[`SCSP_BIT_HVCMP_DIS]
                            : pump_enable_pin; // R18
    // armed only after both supplies passed enable thresholds
    fault_now = armed && (logic_uv || (hv_cmp_on && hv_uv)); // R17 R22
    sck_rise = ser.sck && !sck_q;
    sck_fall = !ser.sck && sck_q;
    cs_fall = !ser.chip_select_n && cs_n_q;
    cs_rise = ser.chip_select_n && !cs_n_q;
  end

  // serial shift engine and register file
  always_comb begin
    next_regs = regs;
    next_shreg = shreg;
    next_sck_q = ser.sck;
    next_cs_n_q = ser.chip_select_n;
    next_sdo = sdo_out;
    next_sdo_oe = sdo_oe_out;
    if (serial_mode && state != SCSP_ST_POR) begin
      if (cs_fall) begin
        // capture the held word; its MSB goes out at once
        next_shreg = {regs.config_fault_register, regs.switch_output_register}; // R7
        next_sdo = regs.config_fault_register[`SCSP_BIT_WR_EN]; // R4
        next_sdo_oe = 1'b1;
      end else if (!ser.chip_select_n) begin
        if (sck_rise) begin
          // oldest bit falls off the top, so the last 16 bits win
          next_shreg = {shreg[`SCSP_FRAME_MSB-1:0], ser.sdi}; // R5 R7 R25
        end else if (sck_fall) begin
          next_sdo = shreg[`SCSP_FRAME_MSB]; // R6
        end
      end else begin
        next_sdo_oe = 1'b0;
      end
      if (cs_rise && shreg[`SCSP_FRAME_MSB]) begin // R8
        // write-enable bit itself is not stored
        next_regs.config_fault_register = {1'b0, shreg[`SCSP_FRAME_MSB-1:8]}; // R9 R11
        next_regs.switch_output_register = shreg[7:0]; // R9 R10
      end
    end else begin
      next_sdo_oe = 1'b0;
    end
    // status bit: hardware set beats a software clear
    if (fault_now) begin
      next_regs.config_fault_register[`SCSP_BIT_FAULT_STATUS_BIT] = 1'b1; // R20
    end
    if (!rst_n_in) begin
      next_regs = '{default: `SCSP_REG_RESET}; // R13
      next_shreg = '0;
      next_sck_q = 1'b0;
      next_cs_n_q = 1'b1; // R3
      next_sdo = 1'b0;
      next_sdo_oe = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    regs <= next_regs;
    shreg <= next_shreg;
    sck_q <= next_sck_q;
    cs_n_q <= next_cs_n_q;
    sdo_out <= next_sdo;
    sdo_oe_out <= next_sdo_oe;
  end

  // power-up wait, fault supervision, output drive
  always_comb begin
    next_state = state;
    next_por_cnt = por_cnt;
    next_armed = armed;
    next_pump_low_seen = pump_low_seen;
    next_hv = `SCSP_HV_ALL_OFF;
    next_pump_run = 1'b0;
    next_fault_n = 1'b0;
    next_fault_oe = 1'b0;
    next_sleep = serial_mode && regs.config_fault_register[`SCSP_BIT_SLEEP];
    next_cmp_en = hv_cmp_on;
    if (logic_ready && hv_ready) begin
      next_armed = 1'b1; // R19
    end
    unique case (state)
      SCSP_ST_POR: begin
        // serial and switch control inputs are not trusted until the power-on time has run out
        if (por_cnt == `SCSP_POR_CNT_W'(POR_CYCLES - 1)) begin
          next_state = SCSP_ST_RUN; // R24
        end else begin
          next_por_cnt = por_cnt + 1'b1;
        end
      end
      SCSP_ST_RUN: begin
        if (serial_mode) begin
          next_hv = regs.switch_output_register[3:0]; // R10
        end else if (!polarity) begin
          next_hv = {parallel_ctrl_4, parallel_ctrl_3, parallel_ctrl_2,
                     parallel_ctrl_1}; // R15
        end
        next_pump_run = eff_pump;
        if (fault_now && !eff_shutdown_dis) begin
          next_state = SCSP_ST_SHUT; // R21
          next_hv = `SCSP_HV_ALL_OFF;
          next_pump_run = 1'b0;
          next_pump_low_seen = 1'b0;
        end
      end
      SCSP_ST_SHUT: begin
        // restart needs pump enable seen low, then high, with fault gone
        if (!eff_pump) begin
          next_pump_low_seen = 1'b1; // R21
        end else if (pump_low_seen && !fault_now) begin
          next_state = SCSP_ST_RUN;
        end
      end
    endcase
    if (fault_now) begin
      next_fault_oe = 1'b1; // R17 R20
    end
    if (!rst_n_in) begin
      next_state = SCSP_ST_POR;
      next_por_cnt = '0;
      next_armed = 1'b0;
      next_pump_low_seen = 1'b0;
      next_hv = `SCSP_HV_ALL_OFF;
      next_pump_run = 1'b0;
      next_fault_oe = 1'b0;
      next_sleep = 1'b0;
      next_cmp_en = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    state <= next_state;
    por_cnt <= next_por_cnt;
    armed <= next_armed;
    pump_low_seen <= next_pump_low_seen;
    {hv_output_d_out, hv_output_c_out, hv_output_b_out, hv_output_a_out} <= next_hv;
    pump_run_out <= next_pump_run;
    fault_out_n_out <= next_fault_n;
    fault_out_n_oe_out <= next_fault_oe;
    sleep_out <= next_sleep;
    hv_comparator_enable_out <= next_cmp_en;
  end
endmodule

//--- scsp_checker.sv
// port assertions for the switch control block
`timescale 1ns/1ps
module scsp_checker (
  input logic clk_in,
  input logic rst_n_in,
  input logic mode_select_in,
  input logic polarity_in,
  input logic sck_ctrl1_in,
  input logic sdi_ctrl2_in,
  input logic sdo_ctrl3_in,
  input logic chip_select_n_in,
  input logic fault_shutdown_pin_in,
  input logic logic_uv_fault_in,
  input logic hv_uv_fault_in,
  input logic logic_supply_ready_in,
  input logic hv_supply_ready_in,
  input logic sdo_oe_out,
  input logic fault_out_n_out,
  input logic fault_out_n_oe_out,
  input logic hv_output_a_out,
  input logic hv_output_b_out,
  input logic hv_output_c_out,
  input logic hv_output_d_out,
  input logic pump_run_out,
  input logic sleep_out
);
  logic [3:0] stab_cnt;
  logic [3:0] hv;
  assign hv = {hv_output_d_out, hv_output_c_out, hv_output_b_out, hv_output_a_out};
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // pins must sit still long enough to clear the synchronisers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !$stable({mode_select_in, polarity_in, sck_ctrl1_in, sdi_ctrl2_in,
        sdo_ctrl3_in, chip_select_n_in}))
      stab_cnt <= 4'h0;
    else if (stab_cnt != 4'hf)
      stab_cnt <= stab_cnt + 4'h1;
  end
  property p_reset_quiet;
    $rose(rst_n_in) |-> hv == 4'h0 && !sdo_oe_out && !fault_out_n_oe_out && !pump_run_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs live after reset");
  property p_open_drain;
    !fault_out_n_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("fault pin driven high");
  property p_sdo_idle;
    (chip_select_n_in || mode_select_in)[*5] |-> !sdo_oe_out;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("sdo driven while idle");
  property p_par_map;
    stab_cnt > 4'h3 && $stable({mode_select_in, polarity_in, sck_ctrl1_in, sdi_ctrl2_in,
      sdo_ctrl3_in, chip_select_n_in}) && mode_select_in && !polarity_in && pump_run_out &&
      !fault_out_n_oe_out
      |-> hv == {chip_select_n_in, sdo_ctrl3_in, sdi_ctrl2_in, sck_ctrl1_in};
  endproperty
  a_par_map: assert property (p_par_map) else $error("parallel map wrong");
  property p_fault_on;
    (logic_uv_fault_in && logic_supply_ready_in && hv_supply_ready_in)[*5] |-> fault_out_n_oe_out;
  endproperty
  a_fault_on: assert property (p_fault_on) else $error("fault not flagged");
  property p_fault_off;
    (!logic_uv_fault_in && !hv_uv_fault_in)[*5] |-> !fault_out_n_oe_out;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault pin not released");
  property p_shutdown;
    (mode_select_in && !fault_shutdown_pin_in)[*4] ##0 fault_out_n_oe_out
      |-> ##[0:4] (hv == 4'h0 && !pump_run_out);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("no shutdown on fault");
  property p_par_sleep;
    mode_select_in[*4] |-> !sleep_out;
  endproperty
  a_par_sleep: assert property (p_par_sleep) else $error("sleep in parallel mode");
endmodule

bind scsp_top scsp_checker i_scsp_checker (.*);

//--- scsp_host.sv
// host model driving the serial pins
`timescale 1ns/1ps
module scsp_host (
  input wire logic clk_in,
  input wire logic sdo_in,
  output logic sck_out,
  output logic sdi_out,
  output logic cs_n_out
);
  // pull-down on data and clock, pull-up on select while idle
  initial begin
    sck_out = 1'b0;
    sdi_out = 1'b0;
    cs_n_out = 1'b1;
  end
  task automatic xfer(input int n, input logic [31:0] w, output logic [31:0] r);
    r = '0;
    cs_n_out <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_out <= w[i];
      repeat (6) @(posedge clk_in);
      r[i] = sdo_in;
      sck_out <= 1'b1;
      repeat (6) @(posedge clk_in);
      sck_out <= 1'b0;
    end
    repeat (6) @(posedge clk_in);
    cs_n_out <= 1'b1;
    sdi_out <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask
endmodule

//--- scsp_top_bench.sv
// self-checking bench for the switch control block
`timescale 1ns/1ps
module scsp_top_bench;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic mode = 1'b0;
  logic pump_pin = 1'b1;
  logic flt_pin = 1'b1;
  logic luv = 1'b0;
  logic hvuv = 1'b0;
  logic rdy = 1'b1;
  logic [3:0] par = 4'h8;
  logic h_sck, h_sdi, h_cs_n, sdo, sdo_oe, pump_run, sleep;
  logic [3:0] hv;
  logic hv_cmp_en;
  logic [7:0] cfg = 8'h00;
  logic [7:0] sw = 8'h00;
  logic [31:0] w, r;
  int seed = 13;
  int fail_count = 0;
  int check_count = 0;
  logic [3:0] codes [8] = '{4'h0, 4'h3, 4'h5, 4'h6, 4'h9, 4'ha, 4'hc, 4'hf};
  initial forever #25 clk_in = ~clk_in;
  scsp_top #(.POR_CYCLES(20)) i_scsp_top (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .mode_select_in(mode),
    .polarity_in(1'b0),
    .sck_ctrl1_in(mode ? par[0] : h_sck),
    .sdi_ctrl2_in(mode ? par[1] : h_sdi),
    .sdo_ctrl3_in(par[2]),
    .chip_select_n_in(mode ? par[3] : h_cs_n),
    .pump_enable_pin_in(pump_pin),
    .fault_shutdown_pin_in(flt_pin),
    .logic_uv_fault_in(luv),
    .hv_uv_fault_in(hvuv),
    .logic_supply_ready_in(rdy),
    .hv_supply_ready_in(rdy),
    .sdo_out(sdo),
    .sdo_oe_out(sdo_oe),
    .fault_out_n_out(),
    .fault_out_n_oe_out(),
    .hv_output_a_out(hv[0]),
    .hv_output_b_out(hv[1]),
    .hv_output_c_out(hv[2]),
    .hv_output_d_out(hv[3]),
    .pump_run_out(pump_run),
    .sleep_out(sleep),
    .hv_comparator_enable_out(hv_cmp_en)
  );
  scsp_host i_scsp_host (
    .clk_in(clk_in),
    .sdo_in(sdo_oe ? sdo : 1'b0),
    .sck_out(h_sck),
    .sdi_out(h_sdi),
    .cs_n_out(h_cs_n)
  );
  task automatic check(input logic [31:0] seen, exp, input string name);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [15:0] exp_rb();
    return {1'b0, cfg[6:0], sw};
  endfunction
  task automatic frame(input int n, input logic [31:0] v);
    i_scsp_host.xfer(n, v, r);
    check(r[n-1 -: 16], exp_rb(), "readback");
    if (v[15]) begin
      cfg = {1'b0, v[14:8]};
      sw = v[7:0];
    end
  endtask
  task automatic pulse_fault();
    luv <= 1'b1;
    repeat (10) @(posedge clk_in);
    luv <= 1'b0;
    repeat (10) @(posedge clk_in);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (30) @(posedge clk_in);
    for (int k = 0; k < 10; k++) begin
      w = $random(seed);
      w[14] = 1'b0;
      w[7:4] = 4'h0;
      if (k == 0) w[15:0] = 16'h800f;
      if (k == 1) w[15] = 1'b0;
      frame(16, w);
      check(sleep, cfg[5], "sleep");
      check(hv_cmp_en, !cfg[3], "cmp");
      check(pump_run, cfg[1], "pump");
      if (!cfg[5]) check(hv, sw[3:0], "hv");
    end
    w = {16'($random(seed)), 16'h8203};
    frame(32, w);
    check(r[15:0], w[31:16], "chain");
    // pin says no shutdown, register bit says shutdown
    pulse_fault();
    check(hv, 4'h0, "hv");
    check(pump_run, 1'b0, "pump");
    cfg[6] = 1'b1;
    frame(16, 32'h0);
    frame(16, 32'h8003);
    frame(16, 32'h8203);
    check(hv, 4'h3, "hv");
    check(pump_run, 1'b1, "pump");
    flt_pin <= 1'b0;
    mode <= 1'b1;
    repeat (8) @(posedge clk_in);
    foreach (codes[k]) begin
      par <= codes[k];
      repeat (8) @(posedge clk_in);
      check(hv, codes[k], "par");
    end
    pulse_fault();
    check(hv, 4'h0, "par");
    pump_pin <= 1'b0;
    repeat (12) @(posedge clk_in);
    pump_pin <= 1'b1;
    repeat (8) @(posedge clk_in);
    check(hv, 4'hf, "par");
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    final_report();
  end
endmodule
